//--- include/arb_consts.vh
// Purpose: constants for the result-ready mask and bulk readback block
// Assumes: byte-wide register map, 16-bit instruction phase (read flag + 15-bit address)
// Notes: every offset and field position lives here, plus the instruction length and the mode, clear and mask reset values
//
// What this block does
// - oscillator keeps running while ready never asserts
// - ready combines only unmasked channels' full flags
// - sixteen channel results at adjacent addresses
// - autodecrement from 0x021F returns 32 bytes
// - direct mode: many instructions, one frame
// - addressing select: 0 autodecrement, 1 direct
// - state clear resets filters, counters, sequencer
// - state clear bit clears itself when done
`ifndef ARB_CONSTS_VH
`define ARB_CONSTS_VH

`define ARB_INSTR_BITS    16
`define ARB_RW_BIT        15
`define ARB_ADDR_MODE     15'h0001
`define ARB_MODE_BIT      7
`define ARB_MODE_RST      8'h00
`define ARB_ADDR_CLEAR    15'h0181
`define ARB_CLEAR_BIT     0
`define ARB_CLEAR_RST     1'b1
`define ARB_ADDR_MASK_LO  15'h0184
`define ARB_ADDR_MASK_HI  15'h0185
`define ARB_MASK_LO_RST   8'hfe
`define ARB_MASK_HI_RST   8'hff
`define ARB_ADDR_FULL_LO  15'h01b0
`define ARB_ADDR_FULL_HI  15'h01b1
`define ARB_ADDR_AVG_BASE 15'h0200
`define ARB_ADDR_AVG_TOP  15'h021f

`endif

//--- logic/arb_skid_fifo.v
// Purpose: small buffer between the sample source and the accumulators
// Assumes: one clock, source and sink share it
// Notes: in_ready_o drops when full so the source stalls instead of losing a word
`timescale 1ns/10ps
module arb_skid_fifo #(
	parameter WIDTH = 20,
	parameter DEPTH = 2,
	parameter AW    = 1
) (
	input  wire             core_clk_i,
	input  wire             rstn_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage entries
	reg [AW-1:0]    wr_ptr;          // next slot to fill
	reg [AW-1:0]    rd_ptr;          // oldest slot
	reg [AW:0]      count;           // entries held
	wire            push;
	wire            pop;

	assign in_ready_o  = (count != DEPTH[AW:0]);
	assign out_valid_o = (count != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// pointer wrap assumes DEPTH is a power of two
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push & ~pop) begin
				count <= count + {{AW{1'b0}}, 1'b1};
			end else if (pop & ~push) begin
				count <= count - {{AW{1'b0}}, 1'b1};
			end
		end
	end

	// data array carries no reset; only valid entries are ever read out
	always @(posedge core_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule // arb_skid_fifo

//--- logic/arb_ready_readback.v
// Purpose: per-channel accumulators, masked ready output and SPI register readback
// Assumes: SPI mode 0, MSB first, pins oversampled by core_clk_i (sclk well below clk/4)
// Notes: average depth is a power of two set by ACC_SHIFT
`timescale 1ns/10ps
`include "arb_consts.vh"
module arb_ready_readback #(
	parameter NCH       = 16,
	parameter ACC_SHIFT = 2
) (
	input  wire        core_clk_i,
	input  wire        rstn_i,
	input  wire        spi_sclk_i,
	input  wire        spi_cs_n_i,
	input  wire        spi_mosi_i,
	output wire        spi_miso_o,
	output wire        spi_miso_oe_n_o,
	input  wire        sample_valid_i,
	output wire        sample_ready_o,
	input  wire [3:0]  sample_chan_i,
	input  wire [15:0] sample_data_i,
	input  wire        burst_stop_en_i,
	output wire        results_ready_n_o,
	output wire        osc_run_o,
	output wire        seq_clear_o
);
	localparam SW = 16 + ACC_SHIFT; // sum width, cannot overflow at full depth

	// pin synchronisers, three stages each
	reg [2:0]  sclk_sync;
	reg [2:0]  cs_sync;
	reg [2:0]  mosi_sync;
	reg        sclk_lvl;           // filtered sclk level
	reg        cs_lvl;             // filtered chip select, high = idle
	wire       sclk_rise;
	wire       sclk_fall;

	// configuration and status
	reg        addressing_select;  // 0 autodecrement, 1 direct
	reg [15:0] channel_fill_mask;  // 1 = channel ignored by ready
	reg        clear_bit;          // state clear in progress
	reg [15:0] channel_depth_reached;
	reg [15:0] averaged_result_reg [0:NCH-1];
	reg [SW-1:0] acc_sum [0:NCH-1];
	reg [ACC_SHIFT-1:0] acc_cnt [0:NCH-1];

	// serial engine
	reg [15:0] rx_sh;              // incoming bits
	reg [3:0]  bit_cnt;
	reg        in_instr;           // collecting an instruction phase
	reg        is_read;
	reg [14:0] addr;
	reg        bytes_left;         // one more byte of a two-byte register
	reg [7:0]  tx_sh;              // outgoing byte
	reg        miso;
	reg        miso_oe_n;
	wire [15:0] rx_word;
	wire [14:0] addr_dec;
	wire        wr_now;

	// sample path
	wire        f_valid;
	wire        f_pop;
	wire [19:0] f_data;
	wire [3:0]  f_chan;
	wire [15:0] f_val;
	wire [SW-1:0] sum_next;
	wire        all_masked;
	wire        all_done;
	integer     i;

	// byte read decode, shared by instruction and data phases
	function [7:0] rd_byte;
		input [14:0] a;
		reg   [14:0] off;
		reg   [15:0] w;
		begin
			rd_byte = 8'h00;
			off = a - `ARB_ADDR_AVG_BASE;
			w = averaged_result_reg[off[4:1]];
			if (a >= `ARB_ADDR_AVG_BASE && a <= `ARB_ADDR_AVG_TOP) begin
				rd_byte = off[0] ? w[15:8] : w[7:0];
			end else begin
				case (a)
					`ARB_ADDR_MODE:    rd_byte = {addressing_select, 7'h00};
					`ARB_ADDR_CLEAR:   rd_byte = {7'h00, clear_bit};
					`ARB_ADDR_MASK_LO: rd_byte = channel_fill_mask[7:0];
					`ARB_ADDR_MASK_HI: rd_byte = channel_fill_mask[15:8];
					`ARB_ADDR_FULL_LO: rd_byte = channel_depth_reached[7:0];
					`ARB_ADDR_FULL_HI: rd_byte = channel_depth_reached[15:8];
					default:           rd_byte = 8'h00;
				endcase
			end
		end
	endfunction

	// results occupy two bytes, everything else one
	function is_pair;
		input [14:0] a;
		begin
			is_pair = (a >= `ARB_ADDR_AVG_BASE) && (a <= `ARB_ADDR_AVG_TOP);
		end
	endfunction

	assign sclk_rise = (sclk_sync[1] == sclk_sync[2]) & sclk_sync[2] & ~sclk_lvl;
	assign sclk_fall = (sclk_sync[1] == sclk_sync[2]) & ~sclk_sync[2] & sclk_lvl;
	assign rx_word   = {rx_sh[14:0], mosi_sync[2]};
	assign addr_dec  = addr - 15'h0001;
	assign wr_now    = sclk_rise & ~cs_lvl & ~in_instr & (bit_cnt == 4'd7) & ~is_read;

	// stage 0 feeds only stage 1; filtered levels use stages 1 and 2
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sclk_sync <= 3'h0;
			cs_sync   <= 3'h7;
			mosi_sync <= 3'h0;
			sclk_lvl  <= 1'b0;
			cs_lvl    <= 1'b1;
		end else begin
			sclk_sync <= {sclk_sync[1:0], spi_sclk_i};
			cs_sync   <= {cs_sync[1:0], spi_cs_n_i};
			mosi_sync <= {mosi_sync[1:0], spi_mosi_i};
			if (sclk_sync[1] == sclk_sync[2]) begin
				sclk_lvl <= sclk_sync[2];
			end
			if (cs_sync[1] == cs_sync[2]) begin
				cs_lvl <= cs_sync[2];
			end
		end
	end

	// serial framing: instruction, then data bytes walked by the selected addressing mode
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_sh      <= 16'h0000;
			bit_cnt    <= 4'h0;
			in_instr   <= 1'b1;
			is_read    <= 1'b0;
			addr       <= 15'h0000;
			bytes_left <= 1'b0;
			tx_sh      <= 8'h00;
			miso       <= 1'b0;
			miso_oe_n  <= 1'b1;
		end else if (cs_lvl) begin
			// idle between frames: every frame restarts with an instruction
			bit_cnt   <= 4'h0;
			in_instr  <= 1'b1;
			miso_oe_n <= 1'b1;
			miso      <= 1'b0;
		end else begin
			miso_oe_n <= 1'b0;
			if (sclk_rise) begin
				rx_sh <= rx_word;
				if (in_instr) begin
					if (bit_cnt == 4'd15) begin
						is_read    <= rx_word[`ARB_RW_BIT];
						addr       <= rx_word[14:0];
						bytes_left <= is_pair(rx_word[14:0]);
						tx_sh      <= rd_byte(rx_word[14:0]);
						in_instr   <= 1'b0;
						bit_cnt    <= 4'h0;
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
					end
				end else if (bit_cnt == 4'd7) begin
					bit_cnt <= 4'h0;
					if (addressing_select && !bytes_left) begin
						// direct mode: next instruction may follow in the same frame
						in_instr <= 1'b1;
						tx_sh    <= 8'h00;
					end else begin
						// autodecrement, or the second byte of a result in direct mode: step down one address
						addr       <= addr_dec;
						bytes_left <= 1'b0;
						tx_sh      <= rd_byte(addr_dec);
					end
				end else begin
					bit_cnt <= bit_cnt + 4'h1;
				end
			end else if (sclk_fall) begin
				// falling edge launches the next bit so the host samples it on rising
				miso  <= tx_sh[7];
				tx_sh <= {tx_sh[6:0], 1'b0};
			end
		end
	end

	// configuration writes; clear bit set by software wins over its own completion
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			addressing_select <= 1'b0;
			channel_fill_mask <= {`ARB_MASK_HI_RST, `ARB_MASK_LO_RST};
			clear_bit         <= `ARB_CLEAR_RST;
		end else begin
			if (wr_now && addr == `ARB_ADDR_MODE) begin
				addressing_select <= rx_word[`ARB_MODE_BIT];
			end
			if (wr_now && addr == `ARB_ADDR_MASK_LO) begin
				channel_fill_mask[7:0] <= rx_word[7:0];
			end
			if (wr_now && addr == `ARB_ADDR_MASK_HI) begin
				channel_fill_mask[15:8] <= rx_word[7:0];
			end
			if (wr_now && addr == `ARB_ADDR_CLEAR && rx_word[`ARB_CLEAR_BIT]) begin
				clear_bit <= 1'b1;
			end else if (clear_bit) begin
				clear_bit <= 1'b0;
			end
		end
	end

	// samples are held back while a clear runs, so none lands in a half-cleared filter
	assign f_pop   = f_valid & ~clear_bit;
	assign f_chan  = f_data[19:16];
	assign f_val   = f_data[15:0];
	assign sum_next = acc_sum[f_chan] + {{ACC_SHIFT{1'b0}}, f_val};

	arb_skid_fifo #(
		.WIDTH (20),
		.DEPTH (2),
		.AW    (1)
	) arb_skid_fifo_inst (
		.core_clk_i  (core_clk_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (sample_valid_i),
		.in_ready_o  (sample_ready_o),
		.in_data_i   ({sample_chan_i, sample_data_i}),
		.out_valid_o (f_valid),
		.out_ready_i (~clear_bit),
		.out_data_o  (f_data)
	);

	// accumulate per channel; a full channel drops samples until the next clear
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			channel_depth_reached <= 16'h0000;
			for (i = 0; i < NCH; i = i + 1) begin
				acc_sum[i]             <= {SW{1'b0}};
				acc_cnt[i]             <= {ACC_SHIFT{1'b0}};
				averaged_result_reg[i] <= 16'h0000;
			end
		end else if (clear_bit) begin
			channel_depth_reached <= 16'h0000;
			for (i = 0; i < NCH; i = i + 1) begin
				acc_sum[i]             <= {SW{1'b0}};
				acc_cnt[i]             <= {ACC_SHIFT{1'b0}};
				averaged_result_reg[i] <= 16'h0000;
			end
		end else if (f_pop && !channel_depth_reached[f_chan]) begin
			if (&acc_cnt[f_chan]) begin
				averaged_result_reg[f_chan]   <= sum_next[SW-1:ACC_SHIFT];
				channel_depth_reached[f_chan] <= 1'b1;
				acc_sum[f_chan]               <= {SW{1'b0}};
				acc_cnt[f_chan]               <= {ACC_SHIFT{1'b0}};
			end else begin
				acc_sum[f_chan] <= sum_next;
				acc_cnt[f_chan] <= acc_cnt[f_chan] + {{(ACC_SHIFT-1){1'b0}}, 1'b1};
			end
		end
	end

	// all masked means no channel can ever raise ready: that is the lockout case
	assign all_masked = &channel_fill_mask;
	assign all_done   = &(channel_depth_reached | channel_fill_mask) & ~all_masked;
	assign results_ready_n_o = ~all_done;
	// with ready as stop trigger the oscillator runs until ready asserts, possibly forever
	assign osc_run_o  = ~(burst_stop_en_i & all_done);
	assign seq_clear_o = clear_bit;
	assign spi_miso_o      = miso;
	assign spi_miso_oe_n_o = miso_oe_n;
endmodule // arb_ready_readback

//--- verification/arb_ready_readback_props.sv
// Purpose: concurrent checks on ready, oscillator, clear pulse and miso enable
// Assumes: sees only the ports of arb_ready_readback, one clock domain
// Notes: cs crosses a 3-flop sync, so enable checks use six-cycle windows
`timescale 1ns/10ps
module arb_ready_readback_props #(
	parameter NCH       = 16,
	parameter ACC_SHIFT = 2
) (
	input wire        core_clk_i,
	input wire        rstn_i,
	input wire        spi_sclk_i,
	input wire        spi_cs_n_i,
	input wire        spi_mosi_i,
	input wire        spi_miso_o,
	input wire        spi_miso_oe_n_o,
	input wire        sample_valid_i,
	input wire        sample_ready_o,
	input wire [3:0]  sample_chan_i,
	input wire [15:0] sample_data_i,
	input wire        burst_stop_en_i,
	input wire        results_ready_n_o,
	input wire        osc_run_o,
	input wire        seq_clear_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// oscillator may only stop when ready is the stop trigger and asserted
	property p_osc_free; !burst_stop_en_i |-> osc_run_o; endproperty
	a_osc_free: assert property (p_osc_free) else $error("osc stopped without trigger");
	property p_osc_lock; results_ready_n_o |-> osc_run_o; endproperty
	a_osc_lock: assert property (p_osc_lock) else $error("osc stopped while not ready");
	property p_osc_stop; burst_stop_en_i && !results_ready_n_o |-> !osc_run_o; endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("osc kept running when ready");
	// the clear pulse lasts exactly one cycle
	property p_clr_once; $rose(seq_clear_o) |=> !seq_clear_o; endproperty
	a_clr_once: assert property (p_clr_once) else $error("clear did not end");
	// clearing empties every accumulator, so ready must be released
	property p_clr_rdy; seq_clear_o |=> results_ready_n_o; endproperty
	a_clr_rdy: assert property (p_clr_rdy) else $error("ready held after clear");
	// with no frame and no clear, an asserted ready stands
	property p_rdy_hold; !results_ready_n_o && spi_cs_n_i && !seq_clear_o |=> !results_ready_n_o;
	endproperty
	a_rdy_hold: assert property (p_rdy_hold) else $error("ready dropped by itself");
	property p_oe_frame; !spi_cs_n_i [*6] |-> !spi_miso_oe_n_o; endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("miso not driven in frame");
	property p_oe_idle; spi_cs_n_i [*6] |-> spi_miso_oe_n_o; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");
	c_ready: cover property ($fell(results_ready_n_o));
	c_stop: cover property (!osc_run_o);
	c_clear: cover property ($rose(seq_clear_o));
endmodule // arb_ready_readback_props
bind arb_ready_readback arb_ready_readback_props #(.NCH(NCH), .ACC_SHIFT(ACC_SHIFT)) props_inst (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
	.spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_n_o(spi_miso_oe_n_o),
	.sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
	.sample_chan_i(sample_chan_i), .sample_data_i(sample_data_i),
	.burst_stop_en_i(burst_stop_en_i), .results_ready_n_o(results_ready_n_o),
	.osc_run_o(osc_run_o), .seq_clear_o(seq_clear_o));

//--- verification/arb_spi_host.sv
// Purpose: behavioural spi host, mode 0, msb first, 160 ns bit period
// Assumes: called by the bench through its tasks, one caller at a time
// Notes: low phase longer than high so the device has settled miso at the rise
`timescale 1ns/10ps
module arb_spi_host (
	output logic spi_sclk_o,
	output logic spi_cs_n_o,
	output logic spi_mosi_o,
	input  wire  spi_miso_i
);
	initial begin
		spi_sclk_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end
	// one byte: set data while clock low, both ends sample on the rise
	task xbyte(input [7:0] tx, output [7:0] rx);
		integer i;
		for (i = 7; i >= 0; i--) begin
			spi_mosi_o = tx[i];
			#100 spi_sclk_o = 1'b1;
			rx[i] = spi_miso_i;
			#60 spi_sclk_o = 1'b0;
		end
	endtask
	// instruction phase: read flag then 15-bit address
	task instr(input rw, input [14:0] a);
		logic [7:0] d;
		xbyte({rw, a[14:8]}, d);
		xbyte(a[7:0], d);
	endtask
	task open_frame;
		spi_cs_n_o = 1'b0;
		#100;
	endtask
	// long tail lets a write land before cs rises; mosi toggled so no stale level lingers
	task close_frame;
		#200 spi_cs_n_o = 1'b1;
		spi_mosi_o = ~spi_mosi_o;
		#300;
	endtask
endmodule // arb_spi_host

//--- verification/arb_ready_readback_tb.sv
// Purpose: self-checking bench for masked ready, oscillator stop and bulk readback
// Assumes: depth 4 (ACC_SHIFT 2), host model drives the spi pins
// Notes: channel n gets samples d..d+3, so its average is d+1
`timescale 1ns/10ps
`include "arb_consts.vh"
module arb_ready_readback_tb;
	logic        core_clk_i;
	logic        rstn_i;
	logic        sample_valid_i;
	logic        burst_stop_en_i;
	logic [3:0]  sample_chan_i;
	logic [15:0] sample_data_i;
	wire         spi_sclk, spi_cs_n, spi_mosi, spi_miso, miso_oe_n, miso_w;
	wire         sample_ready, ready_n, osc_run, seq_clear;
	integer      fail_count, checked, n, k;
	logic [7:0]  rx;
	assign miso_w = miso_oe_n ? 1'bz : spi_miso; // device releases miso when idle
	arb_ready_readback #(.NCH(16), .ACC_SHIFT(2)) arb_ready_readback_inst (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .spi_sclk_i(spi_sclk), .spi_cs_n_i(spi_cs_n),
		.spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso), .spi_miso_oe_n_o(miso_oe_n),
		.sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready),
		.sample_chan_i(sample_chan_i), .sample_data_i(sample_data_i),
		.burst_stop_en_i(burst_stop_en_i), .results_ready_n_o(ready_n),
		.osc_run_o(osc_run), .seq_clear_o(seq_clear));
	arb_spi_host arb_spi_host_inst (.spi_sclk_o(spi_sclk), .spi_cs_n_o(spi_cs_n),
		.spi_mosi_o(spi_mosi), .spi_miso_i(miso_w));
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	task end_sim;
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk8(input [7:0] got, input [7:0] exp);
		checked++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	task chk1(input got, input exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	// frames start on a falling edge so no spi pin moves at the sampling edge
	task reg_rd(input [14:0] a, input [7:0] e);
		@(negedge core_clk_i);
		arb_spi_host_inst.open_frame();
		arb_spi_host_inst.instr(1'b1, a);
		arb_spi_host_inst.xbyte(8'h00, rx);
		arb_spi_host_inst.close_frame();
		chk8(rx, e);
	endtask
	task reg_wr(input [14:0] a, input [7:0] d);
		@(negedge core_clk_i);
		arb_spi_host_inst.open_frame();
		arb_spi_host_inst.instr(1'b0, a);
		arb_spi_host_inst.xbyte(d, rx);
		arb_spi_host_inst.close_frame();
	endtask
	// offer one sample and hold it until the buffer takes it
	task put(input [3:0] ch, input [15:0] d);
		integer t;
		logic ok;
		ok = 1'b0;
		sample_chan_i <= ch;
		sample_data_i <= d;
		sample_valid_i <= 1'b1;
		for (t = 0; t < 20 && !ok; t++) begin
			@(negedge core_clk_i);
			ok = (sample_ready === 1'b1);
			@(posedge core_clk_i);
		end
		if (!ok) begin
			fail_count++;
			end_sim();
		end
	endtask
	// bounded wait for ready to reach a level, then compare it
	task wait_rdy(input exp);
		integer t;
		for (t = 0; t < 30 && ready_n !== exp; t++)
			@(negedge core_clk_i);
		chk1(ready_n, exp);
	endtask
	initial begin
		fail_count = 0;
		checked = 0;
		rstn_i = 1'b0;
		sample_valid_i = 1'b0;
		sample_chan_i = 4'h0;
		sample_data_i = 16'h0000;
		burst_stop_en_i = 1'b0;
		repeat (5) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		reg_rd(`ARB_ADDR_CLEAR, 8'h00);
		reg_rd(`ARB_ADDR_MASK_LO, `ARB_MASK_LO_RST);
		reg_rd(`ARB_ADDR_MASK_HI, `ARB_MASK_HI_RST);
		reg_rd(`ARB_ADDR_MODE, `ARB_MODE_RST);
		reg_rd(15'h0002, 8'h00);
		@(posedge core_clk_i);
		burst_stop_en_i <= 1'b1;
		reg_wr(`ARB_ADDR_MASK_LO, 8'h00);
		reg_wr(`ARB_ADDR_MASK_HI, 8'h00);
		@(posedge core_clk_i);
		for (k = 0; k < 4; k++) begin
			for (n = 0; n < 16; n++) begin
				if (n == 15 && k == 3) begin
					// drop valid so the sample already taken is not pushed again
					sample_valid_i <= 1'b0;
					repeat (4) @(posedge core_clk_i);
					chk1(ready_n, 1'b1);
					chk1(osc_run, 1'b1);
				end
				put(n[3:0], {4'h0, n[3:0], 8'h20} + k[15:0]);
			end
		end
		sample_valid_i <= 1'b0;
		wait_rdy(1'b0);
		chk1(osc_run, 1'b0);
		reg_rd(`ARB_ADDR_FULL_LO, 8'hff);
		reg_rd(`ARB_ADDR_FULL_HI, 8'hff);
		@(negedge core_clk_i);
		arb_spi_host_inst.open_frame();
		arb_spi_host_inst.instr(1'b1, `ARB_ADDR_AVG_TOP);
		for (n = 15; n >= 0; n--) begin
			arb_spi_host_inst.xbyte(8'h00, rx);
			chk8(rx, {4'h0, n[3:0]});
			arb_spi_host_inst.xbyte(8'h00, rx);
			chk8(rx, 8'h21);
		end
		arb_spi_host_inst.close_frame();
		reg_wr(`ARB_ADDR_MASK_LO, 8'hff);
		reg_wr(`ARB_ADDR_MASK_HI, 8'hff);
		wait_rdy(1'b1);
		chk1(osc_run, 1'b1);
		reg_wr(`ARB_ADDR_MASK_LO, 8'hfe);
		wait_rdy(1'b0);
		reg_wr(`ARB_ADDR_MODE, 8'h80);
		@(negedge core_clk_i);
		arb_spi_host_inst.open_frame();
		arb_spi_host_inst.instr(1'b1, 15'h0201);
		arb_spi_host_inst.xbyte(8'h00, rx);
		chk8(rx, 8'h00);
		arb_spi_host_inst.xbyte(8'h00, rx);
		chk8(rx, 8'h21);
		arb_spi_host_inst.instr(1'b1, 15'h0207);
		arb_spi_host_inst.xbyte(8'h00, rx);
		chk8(rx, 8'h03);
		arb_spi_host_inst.xbyte(8'h00, rx);
		chk8(rx, 8'h21);
		arb_spi_host_inst.instr(1'b0, `ARB_ADDR_CLEAR);
		arb_spi_host_inst.xbyte(8'h01, rx);
		arb_spi_host_inst.close_frame();
		wait_rdy(1'b1);
		chk1(osc_run, 1'b1);
		reg_rd(`ARB_ADDR_CLEAR, 8'h00);
		reg_rd(`ARB_ADDR_FULL_LO, 8'h00);
		reg_rd(`ARB_ADDR_MASK_LO, 8'hfe);
		// back to autodecrement: bulk read, then the state reset in its own frame
		reg_wr(`ARB_ADDR_MODE, 8'h00);
		reg_rd(`ARB_ADDR_MODE, `ARB_MODE_RST);
		@(negedge core_clk_i);
		arb_spi_host_inst.open_frame();
		arb_spi_host_inst.instr(1'b1, `ARB_ADDR_AVG_TOP);
		arb_spi_host_inst.xbyte(8'h00, rx);
		chk8(rx, 8'h00);
		arb_spi_host_inst.xbyte(8'h00, rx);
		chk8(rx, 8'h00);
		arb_spi_host_inst.close_frame();
		reg_wr(`ARB_ADDR_CLEAR, 8'h01);
		wait_rdy(1'b1);
		reg_rd(`ARB_ADDR_CLEAR, 8'h00);
		reg_rd(`ARB_ADDR_MASK_LO, 8'hfe);
		end_sim();
	end
endmodule // arb_ready_readback_tb
